// [dv/field_model.sv]
// Field side model: contact sensors, analog transmitters and operator acknowledge
`timescale 1ns/1ps
module field_model (
    input wire logic clk,
    output logic [alarm_seq_pkg::NUM_DIN-1:0] din_pin,
    output logic [alarm_seq_pkg::NUM_AIN*alarm_seq_pkg::AW-1:0] ain_value,
    output logic ack_pin
);
    import alarm_seq_pkg::*;

    initial begin
        din_pin = '0;
        ain_value = '0;
        ack_pin = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic set_din(input logic [NUM_DIN-1:0] v);
        @(posedge clk) din_pin <= v;
    endtask : set_din

    // One channel moves; the others keep their values
    task automatic set_ain(input int ch, input logic [AW-1:0] v);
        @(posedge clk) ain_value[ch*AW +: AW] <= v;
    endtask : set_ain

    task automatic set_ain0(input logic [AW-1:0] v);
        set_ain(0, v);
    endtask : set_ain0

    // Held long enough to pass the input synchroniser
    task automatic press_ack();
        @(posedge clk) ack_pin <= 1'b1;
        repeat (6) @(posedge clk);
        ack_pin <= 1'b0;
    endtask : press_ack
endmodule : field_model

// [dv/tb.sv]
// Self-checking testbench of the alarm sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb;
    import alarm_seq_pkg::*;

    logic clk, resetn, ack_pin, wr, rd, beeper, alarm_pending, auto_mode, report_req, page_req;
    logic [NUM_DIN-1:0] din_pin;
    logic [NUM_AIN*AW-1:0] ain_value;
    logic [7:0] addr, relay_out;
    logic [31:0] wdata, rdata, r;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] amode_tab [7] = '{16'h0300, 16'h0180, 16'h00c0, 16'h0200,
                                   16'h1180, 16'h1300, 16'h1100};
    logic exp_tab [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    alarm_seq #(.DEBOUNCE_CYC_MS(2), .TICK_CYCLES(4), .BEEP_MS(5)) alarm_seq_inst (
        .clk(clk), .resetn(resetn), .din_pin(din_pin), .ain_value(ain_value),
        .ack_pin(ack_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .relay_out(relay_out), .beeper(beeper), .alarm_pending(alarm_pending),
        .auto_mode(auto_mode), .report_req(report_req), .page_req(page_req));

    field_model field_model_inst (.clk(clk), .din_pin(din_pin), .ain_value(ain_value),
        .ack_pin(ack_pin));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
        end
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) begin
            addr <= a;
            rd <= 1'b1;
        end
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    function automatic logic [31:0] stepw(input logic [7:0] s, input logic [7:0] c,
                                          input wait_e w, input logic [3:0] i,
                                          input logic [7:0] dly);
        step_s st;
        st = '0;
        st.set_mask = s;
        st.clr_mask = c;
        st.wait_kind = w;
        st.in_sel = i;
        st.delay_ms = dly;
        return st;
    endfunction : stepw

    task automatic end_test(input string n);
        $display("test %s done: %0d checks, %0d errors", n, comparisons, errors);
    endtask : end_test

    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        task_s tk;
        int seen;
        resetn = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        r = '0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(ADDR_CTRL, r); `CHK("ctrl", 32'h0, r)
        rd_reg(ADDR_STATUS, r); `CHK("status", 5'h02, r[4:0])
        wr_reg(8'h08, 32'hffff_ffff);
        rd_reg(8'h08, r); `CHK("unmapped", 32'h0, r)
        end_test("reset");

        wr_reg(ADDR_DPOL, 32'h01);
        wait_cyc(30);
        rd_reg(ADDR_ACTIVE, r); `CHK("dpol", 8'hfe, r[7:0])
        field_model_inst.set_din(8'h01);
        wait_cyc(2);
        rd_reg(ADDR_ACTIVE, r); `CHK("bounce", 1'b0, r[0])
        wait_cyc(30);
        rd_reg(ADDR_ACTIVE, r); `CHK("settled", 8'hff, r[7:0])
        field_model_inst.set_din(8'hfe);
        wait_cyc(30);
        rd_reg(ADDR_ACTIVE, r); `CHK("din all", 8'h00, r[7:0])
        field_model_inst.set_din(8'h00);
        wait_cyc(30);
        end_test("digital");

        wr_reg(ADDR_LIM_BASE, 32'h0020_0100);
        for (int i = 0; i < 7; i++) begin
            wr_reg(ADDR_AMODE, {31'h0, amode_tab[i][12]});
            field_model_inst.set_ain0(amode_tab[i][11:0]);
            wait_cyc(4);
            rd_reg(ADDR_ACTIVE, r); `CHK("analog", exp_tab[i], r[8])
        end
        wr_reg(ADDR_AMODE, 32'h0);
        field_model_inst.set_ain0(12'h180);
        for (int i = 1; i < NUM_AIN; i++) begin
            wr_reg(ADDR_LIM_BASE + 8'(i), 32'h0020_0100);
            field_model_inst.set_ain(i, 12'h300);
        end
        wait_cyc(4);
        rd_reg(ADDR_ACTIVE, r); `CHK("analog hi", 3'h7, r[11:9])
        wr_reg(ADDR_AMODE, 32'he);
        for (int i = 1; i < NUM_AIN; i++) field_model_inst.set_ain(i, 12'h180);
        wait_cyc(4);
        rd_reg(ADDR_ACTIVE, r); `CHK("analog win", 3'h7, r[11:9])
        wr_reg(ADDR_AMODE, 32'h0);
        wait_cyc(4);
        rd_reg(ADDR_ACTIVE, r); `CHK("analog mid", 3'h0, r[11:9])
        end_test("analog");

        wr_reg(ADDR_CTRL, 32'h01);
        field_model_inst.set_ain0(12'h300);
        wait_cyc(6);
        `CHK("beep on", 1'b1, beeper)
        `CHK("pending", 1'b1, alarm_pending)
        field_model_inst.press_ack();
        wait_cyc(4);
        `CHK("beep ack", 1'b0, beeper)
        `CHK("pend ack", 1'b0, alarm_pending)
        field_model_inst.set_ain0(12'h180);
        wait_cyc(4);
        field_model_inst.set_ain0(12'h300);
        wait_cyc(14);
        `CHK("beep hold", 1'b1, beeper)
        wait_cyc(22);
        `CHK("beep expire", 1'b0, beeper)
        field_model_inst.set_ain0(12'h180);
        end_test("beeper");

        wr_reg(ADDR_MANOUT, 32'h5a);
        wait_cyc(3);
        `CHK("manual out", 8'h5a, relay_out)
        wr_reg(ADDR_MANOUT, 32'h00);
        wr_reg(ADDR_NSTEP, 32'h22);
        wr_reg(ADDR_SU_BASE, stepw(8'h01, 8'h00, W_NONE, 4'h0, 8'h00));
        wr_reg(ADDR_SU_BASE + 8'h01, stepw(8'h02, 8'h00, W_DELAY, 4'h0, 8'h02));
        wr_reg(ADDR_SD_BASE, stepw(8'h00, 8'hff, W_NONE, 4'h0, 8'h00));
        wr_reg(ADDR_SD_BASE + 8'h01, stepw(8'h00, 8'h00, W_INPUT, 4'h9, 8'h00));
        tk = '0;
        tk.enable = 1'b1;
        tk.in_a = 4'h8;
        tk.out_sel = 3'h7;
        tk.out_level = 1'b1;
        tk.do_report = 1'b1;
        wr_reg(ADDR_TASK_BASE, tk);
        tk.in_b = 4'h9;
        tk.use_b = 1'b1;
        tk.and_b = 1'b1;
        tk.out_sel = 3'h6;
        tk.do_report = 1'b0;
        wr_reg(ADDR_TASK_BASE + 8'h01, tk);
        tk = '0;
        tk.enable = 1'b1;
        tk.do_page = 1'b1;
        tk.do_shut = 1'b1;
        wr_reg(ADDR_TASK_BASE + 8'h0f, tk);
        field_model_inst.set_ain0(12'h300);
        wait_cyc(10);
        `CHK("idle task", 1'b0, relay_out[7])
        `CHK("idle report", 1'b0, report_req)
        wr_reg(ADDR_CTRL, 32'h03);
        wait_cyc(4);
        `CHK("steps", 2'b01, relay_out[1:0])
        `CHK("delay", 1'b0, auto_mode)
        wait_cyc(40);
        `CHK("auto", 1'b1, auto_mode)
        `CHK("task out", 1'b1, relay_out[7])
        `CHK("steps done", 2'b11, relay_out[1:0])
        `CHK("and task", 1'b0, relay_out[6])
        `CHK("report", 1'b1, report_req)
        field_model_inst.set_ain0(12'h180);
        wait_cyc(4);
        field_model_inst.set_ain0(12'h300);
        wait_cyc(6);
        `CHK("auto silent", 1'b0, beeper)
        end_test("startup");

        seen = 0;
        field_model_inst.set_din(8'h01);
        for (int i = 0; i < 60 && seen == 0; i++) begin
            wait_cyc(1);
            if (page_req === 1'b1) seen = 1;
        end
        `CHK("page", 1, seen)
        wait_cyc(20);
        `CHK("shut mode", 1'b0, auto_mode)
        `CHK("shut out", 8'h00, relay_out)
        rd_reg(ADDR_STATUS, r); `CHK("shut wait", 3'h3, r[4:2])
        field_model_inst.set_ain(1, 12'h300);
        wait_cyc(4);
        rd_reg(ADDR_STATUS, r); `CHK("shut done", 3'h0, r[4:2])
        field_model_inst.set_ain(1, 12'h180);
        field_model_inst.set_din(8'h00);
        wait_cyc(30);
        end_test("shutdown");

        wr_reg(ADDR_NSTEP, 32'h11);
        wr_reg(ADDR_SU_BASE, stepw(8'h01, 8'h00, W_REQUIRE, 4'h9, 8'h00));
        wr_reg(ADDR_CTRL, 32'h04);
        wait_cyc(40);
        `CHK("abort", 1'b0, auto_mode)
        rd_reg(ADDR_STATUS, r); `CHK("abort mode", 3'h0, r[4:2])
        wr_reg(ADDR_CTRL, 32'h10);
        wait_cyc(3);
        `CHK("auto cmd", 1'b1, auto_mode)
        wr_reg(ADDR_CTRL, 32'h20);
        wait_cyc(3);
        `CHK("manual cmd", 1'b0, auto_mode)
        end_test("abort");
        stop_test();
    end
endmodule : tb

// [rtl/alarm_seq.sv]
// Active state classification, beeper and startup/task/shutdown sequencing
`timescale 1ns/1ps
module alarm_seq #(
    parameter int DEBOUNCE_CYC_MS = alarm_seq_pkg::DEBOUNCE_MS,
    parameter int TICK_CYCLES = alarm_seq_pkg::TICK_CYC,
    parameter int BEEP_MS = alarm_seq_pkg::BEEP_TIMEOUT_MS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [alarm_seq_pkg::NUM_DIN-1:0] din_pin,
    input wire logic [alarm_seq_pkg::NUM_AIN*alarm_seq_pkg::AW-1:0] ain_value,
    input wire logic ack_pin,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic [alarm_seq_pkg::NUM_OUT-1:0] relay_out,
    output logic beeper,
    output logic alarm_pending,
    output logic auto_mode,
    output logic report_req,
    output logic page_req
);
    import alarm_seq_pkg::*;

    typedef enum logic [2:0] {S_MANUAL, S_STARTUP, S_AUTO, S_SHUTDOWN} mode_e;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl_q;
    logic [NUM_DIN-1:0] dpol_q;
    logic [NUM_AIN-1:0] amode_q;
    logic [NUM_OUT-1:0] manout_q;
    logic [3:0] nsu_q, nsd_q;
    logic [2*AW-1:0] lim_q [NUM_AIN];
    logic [31:0] su_q [MAX_STEPS];
    logic [31:0] sd_q [MAX_STEPS];
    logic [31:0] task_q [MAX_TASKS];
    logic [31:0] rdata_q;
    mode_e mode_q;
    logic [3:0] step_q;
    logic [7:0] wait_q;
    logic [NUM_OUT-1:0] out_q;
    logic beep_q, pend_q, rep_q, page_q, boot_q;
    logic [31:0] beep_cnt_q;
    logic [NUM_IN-1:0] act_q;
    logic [31:0] tick_cnt_q;
    logic tick;

    wire wr_ctrl = wr && addr == ADDR_CTRL;
    wire cmd_start = wr_ctrl && wdata[CTRL_START];
    wire cmd_shut = wr_ctrl && wdata[CTRL_SHUT];
    wire cmd_auto = wr_ctrl && wdata[CTRL_AUTO];
    wire cmd_manual = wr_ctrl && wdata[CTRL_MANUAL];
    wire cmd_ack = wr_ctrl && wdata[CTRL_ACK];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= CTRL_RESET;
            dpol_q <= '0;
            amode_q <= '0;
            manout_q <= '0;
            nsu_q <= '0;
            nsd_q <= '0;
            for (int i = 0; i < NUM_AIN; i++) lim_q[i] <= '0;
            for (int i = 0; i < MAX_STEPS; i++) begin
                su_q[i] <= '0;
                sd_q[i] <= '0;
            end
            for (int i = 0; i < MAX_TASKS; i++) task_q[i] <= '0;
        end else if (wr) begin
            if (addr == ADDR_CTRL) ctrl_q <= {30'h0, wdata[CTRL_AUTOSTART], wdata[CTRL_ARMED]};
            if (addr == ADDR_DPOL) dpol_q <= wdata[NUM_DIN-1:0]; // see RULE1
            if (addr == ADDR_AMODE) amode_q <= wdata[NUM_AIN-1:0];
            if (addr == ADDR_MANOUT) manout_q <= wdata[NUM_OUT-1:0];
            if (addr == ADDR_NSTEP) begin
                nsu_q <= wdata[3:0];
                nsd_q <= wdata[7:4];
            end
            if (addr[7:4] == ADDR_LIM_BASE[7:4] && addr[3:0] < NUM_AIN)
                lim_q[addr[1:0]] <= wdata[2*AW-1:0]; // see RULE2
            if (addr[7:4] == ADDR_SU_BASE[7:4] && !addr[3]) su_q[addr[2:0]] <= wdata;
            if (addr[7:4] == ADDR_SD_BASE[7:4] && !addr[3]) sd_q[addr[2:0]] <= wdata;
            if (addr[7:4] == ADDR_TASK_BASE[7:4]) task_q[addr[3:0]] <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick
    assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) tick_cnt_q <= '0;
        else tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Digital inputs: synchroniser and debounce
    logic [NUM_DIN-1:0] sync1_q, sync2_q, deb_q, ack1_q, ack2_q;
    logic [7:0] deb_cnt_q [NUM_DIN];
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            deb_q <= '0;
            for (int i = 0; i < NUM_DIN; i++) deb_cnt_q[i] <= '0;
        end else begin
            sync1_q <= din_pin;
            sync2_q <= sync1_q;
            for (int i = 0; i < NUM_DIN; i++) begin
                if (sync2_q[i] == deb_q[i]) deb_cnt_q[i] <= '0;
                else if (tick) begin
                    if (deb_cnt_q[i] == 8'(DEBOUNCE_CYC_MS - 1)) begin
                        deb_q[i] <= sync2_q[i]; // see RULE18
                        deb_cnt_q[i] <= '0;
                    end else deb_cnt_q[i] <= deb_cnt_q[i] + 8'h1;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack1_q <= '0;
            ack2_q <= '0;
        end else begin
            ack1_q <= {7'h0, ack_pin};
            ack2_q <= ack1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active state classification
    logic [NUM_IN-1:0] act_d;
    always_comb begin
        act_d[NUM_DIN-1:0] = deb_q ^ ~dpol_q; // see RULE1
        for (int i = 0; i < NUM_AIN; i++) begin
            logic [AW-1:0] v, lo, hi;
            v = ain_value[i*AW +: AW];
            lo = lim_q[i][AW-1:0];
            hi = lim_q[i][2*AW-1:AW];
            act_d[NUM_DIN+i] = amode_q[i] ? (v > lo && v < hi) // see RULE4
                                          : (v > hi || v < lo); // see RULE3
        end
    end
    wire any_new = |(act_d & ~act_q);
    wire [15:0] in_vec = 16'(act_q);

    ////////////////////////////////////////////////////////////////////////////
    // Beeper
    wire ack_now = cmd_ack || ack2_q[0];
    wire beep_timeout = beep_q && tick && beep_cnt_q == 32'(BEEP_MS - 1);
    // Leaving manual silences the beeper on the same edge
    wire leave_manual = mode_q == S_MANUAL && (cmd_shut || cmd_start || cmd_auto
                        || (boot_q && ctrl_q[CTRL_AUTOSTART])); // see RULE8
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act_q <= '0;
            beep_q <= 1'b0;
            pend_q <= 1'b0;
            beep_cnt_q <= '0;
        end else begin
            act_q <= act_d;
            if (any_new && ctrl_q[CTRL_ARMED] && mode_q == S_MANUAL && !leave_manual) begin
                beep_q <= 1'b1; // see RULE5
                beep_cnt_q <= '0;
            end else if (ack_now || beep_timeout || mode_q != S_MANUAL || leave_manual) begin
                beep_q <= 1'b0; // see RULE7 RULE8
            end else if (beep_q && tick) begin
                beep_cnt_q <= beep_cnt_q + 32'h1;
            end
            if (any_new) pend_q <= 1'b1; // see RULE6
            else if (ack_now) pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencers and process tasks
    step_s cur;
    assign cur = step_s'(mode_q == S_SHUTDOWN ? sd_q[step_q[2:0]] : su_q[step_q[2:0]]);
    wire cond_ok = sel_in(in_vec, cur.in_sel);
    wire step_go = cur.wait_kind == W_NONE || cur.wait_kind == W_REQUIRE
                || (cur.wait_kind == W_DELAY && wait_q >= cur.delay_ms)
                || (cur.wait_kind == W_INPUT && cond_ok); // see RULE20
    wire step_fail = mode_q == S_STARTUP && cur.wait_kind == W_REQUIRE && !cond_ok;
    wire [NUM_OUT-1:0] step_out = (out_q | cur.set_mask) & ~cur.clr_mask;

    logic [NUM_OUT-1:0] task_out;
    logic t_rep, t_page, t_shut;
    always_comb begin
        task_out = out_q;
        t_rep = 1'b0;
        t_page = 1'b0;
        t_shut = 1'b0;
        for (int i = 0; i < MAX_TASKS; i++) begin // see RULE12
            task_s t;
            logic a, b, c;
            t = task_s'(task_q[i]);
            a = sel_in(in_vec, t.in_a);
            b = sel_in(in_vec, t.in_b);
            c = !t.use_b ? a : (t.and_b ? (a && b) : (a || b));
            if (t.enable && c) begin // see RULE11
                task_out[t.out_sel] = t.out_level; // see RULE13
                t_rep = t_rep | t.do_report;
                t_page = t_page | t.do_page;
                t_shut = t_shut | t.do_shut;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= S_MANUAL;
            step_q <= '0;
            wait_q <= '0;
            out_q <= '0;
            rep_q <= 1'b0;
            page_q <= 1'b0;
            boot_q <= 1'b1;
        end else begin
            // Power-up start stays pending until the first run
            if (mode_q != S_MANUAL) boot_q <= 1'b0;
            rep_q <= 1'b0;
            page_q <= 1'b0;
            case (mode_q)
                S_MANUAL: begin
                    out_q <= manout_q; // see RULE19
                    step_q <= '0;
                    wait_q <= '0;
                    if (cmd_shut) mode_q <= S_SHUTDOWN;
                    else if (cmd_start || (boot_q && ctrl_q[CTRL_AUTOSTART]))
                        mode_q <= S_STARTUP; // see RULE10
                    else if (cmd_auto) mode_q <= S_AUTO; // see RULE19
                end
                S_STARTUP, S_SHUTDOWN: begin
                    if (mode_q == S_STARTUP && (cmd_shut || step_fail)) begin
                        mode_q <= S_SHUTDOWN; // see RULE16
                        step_q <= '0;
                        wait_q <= '0;
                    end else if (step_q >= (mode_q == S_STARTUP ? nsu_q : nsd_q)) begin
                        mode_q <= mode_q == S_STARTUP ? S_AUTO : S_MANUAL; // see RULE15
                        step_q <= '0;
                    end else if (step_go) begin
                        out_q <= step_out; // see RULE9 RULE14
                        step_q <= step_q + 4'h1;
                        wait_q <= '0;
                    end else if (tick && wait_q != 8'hff) wait_q <= wait_q + 8'h1;
                end
                S_AUTO: begin
                    out_q <= task_out; // see RULE17
                    rep_q <= t_rep;
                    page_q <= t_page;
                    if (t_shut || cmd_shut) begin
                        mode_q <= S_SHUTDOWN; // see RULE14
                        step_q <= '0;
                        wait_q <= '0;
                    end else if (cmd_manual) mode_q <= S_MANUAL;
                end
                default: mode_q <= S_MANUAL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) rdata_q <= '0;
        else if (rd) begin
            case (addr)
                ADDR_CTRL: rdata_q <= ctrl_q;
                ADDR_STATUS: rdata_q <= {20'h0, 4'(step_q), 2'h0, boot_q,
                                         3'(mode_q), pend_q, beep_q};
                ADDR_DPOL: rdata_q <= 32'(dpol_q);
                ADDR_AMODE: rdata_q <= 32'(amode_q);
                ADDR_MANOUT: rdata_q <= 32'(manout_q);
                ADDR_ACTIVE: rdata_q <= 32'(act_q);
                ADDR_NSTEP: rdata_q <= {24'h0, nsd_q, nsu_q};
                default: rdata_q <= 32'h0;
            endcase
        end else rdata_q <= '0;
    end

    assign rdata = rdata_q;
    assign relay_out = out_q;
    assign beeper = beep_q;
    assign alarm_pending = pend_q;
    assign auto_mode = mode_q == S_AUTO;
    assign report_req = rep_q;
    assign page_req = page_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    beep_manual_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE8
        beep_q |-> mode_q == S_MANUAL) else $error("beeper outside manual");
    beep_ack_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE7
        (beep_q && ack_now && !any_new) |=> !beep_q) else $error("ack ignored");
    beep_start_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE5
        (any_new && ctrl_q[CTRL_ARMED] && mode_q == S_MANUAL && !leave_manual) |=> beep_q)
        else $error("beeper not started");
    pend_set_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE6
        any_new |=> pend_q) else $error("pending not set");
    task_suspend_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE17
        (mode_q != S_AUTO) |=> !rep_q && !page_q) else $error("task outside auto");
    abort_shut_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE16
        (step_fail && step_q < nsu_q) |=> mode_q == S_SHUTDOWN)
        else $error("startup not aborted");
    startup_done_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE15
        (mode_q == S_STARTUP && step_q >= nsu_q && !cmd_shut && !step_fail) |=> auto_mode)
        else $error("auto not entered");
    manual_out_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE19
        (mode_q == S_MANUAL && $stable(manout_q) && $past(mode_q) == S_MANUAL)
        |-> out_q == manout_q) else $error("manual outputs wrong");
    autostart_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE10
        (mode_q == S_MANUAL && boot_q && ctrl_q[CTRL_AUTOSTART] && !cmd_shut)
        |=> mode_q == S_STARTUP) else $error("autostart missed");
endmodule : alarm_seq

// [rtl/alarm_seq_pkg.sv]
// Constants, types and register map of the active state alarm sequencer
// What this block does
// RULE1: Per digital input, selectable active polarity
// RULE2: Each analog input has low/high limits
// RULE3: Endpoint: active above high or below low
// RULE4: Window: active between low and high limits
// RULE5: Armed alarms sound beeper on active entry
// RULE6: Show pending condition, accept operator acknowledge
// RULE7: Beeper stops on acknowledge or 30 s
// RULE8: Beeper sounds only in manual mode
// RULE9: Startup steps run in order, 8/16 max
// RULE10: Option starts startup automatically after power-up
// RULE11: Each task fires action when condition true
// RULE12: 16 or 64 tasks evaluated concurrently
// RULE13: Task action: outputs, report, page, shutdown
// RULE14: Shutdown steps in order, operator or alarm
// RULE15: Startup complete enters auto, runs tasks
// RULE16: Failed startup condition aborts, full shutdown
// RULE17: Tasks run only in auto mode
// RULE18: Digital change accepted after 125 ms stable
// RULE19: Manual: outputs follow operator; auto command
// RULE20: Step acts now, or waits delay/input
package alarm_seq_pkg;
    localparam int NUM_DIN = 8;
    localparam int NUM_AIN = 4;
    localparam int NUM_OUT = 8;
    localparam int AW = 12;
    localparam int NUM_IN = NUM_DIN + NUM_AIN;
    localparam int MAX_STEPS = 8;
    localparam int MAX_TASKS = 16;
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_CYC = CLK_HZ / 1000;
    localparam int DEBOUNCE_MS = 125;
    localparam int BEEP_TIMEOUT_S = 30;
    localparam int BEEP_TIMEOUT_MS = BEEP_TIMEOUT_S * 1000;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_DPOL = 8'h02;
    localparam logic [7:0] ADDR_AMODE = 8'h03;
    localparam logic [7:0] ADDR_MANOUT = 8'h04;
    localparam logic [7:0] ADDR_ACTIVE = 8'h05;
    localparam logic [7:0] ADDR_NSTEP = 8'h06;
    localparam logic [7:0] ADDR_LIM_BASE = 8'h10;
    localparam logic [7:0] ADDR_SU_BASE = 8'h20;
    localparam logic [7:0] ADDR_SD_BASE = 8'h30;
    localparam logic [7:0] ADDR_TASK_BASE = 8'h40;
    localparam int CTRL_ARMED = 0;
    localparam int CTRL_AUTOSTART = 1;
    localparam int CTRL_START = 2;
    localparam int CTRL_SHUT = 3;
    localparam int CTRL_AUTO = 4;
    localparam int CTRL_MANUAL = 5;
    localparam int CTRL_ACK = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {W_NONE, W_DELAY, W_INPUT, W_REQUIRE} wait_e;
    // Step word: [7:0] set mask, [15:8] clear mask, [19:16] input, [21:20] wait, [31:24] delay ms
    typedef struct packed {
        logic [7:0] delay_ms;
        logic [1:0] pad;
        wait_e wait_kind;
        logic [3:0] in_sel;
        logic [7:0] clr_mask;
        logic [7:0] set_mask;
    } step_s;
    // Task word: [3:0] in A, [7:4] in B, [8] use B, [9] and/or, [10] report,
    // [11] page, [12] shutdown, [15:13] out sel, [16] out level, [17] enable
    typedef struct packed {
        logic [13:0] pad;
        logic enable;
        logic out_level;
        logic [2:0] out_sel;
        logic do_shut;
        logic do_page;
        logic do_report;
        logic and_b;
        logic use_b;
        logic [3:0] in_b;
        logic [3:0] in_a;
    } task_s;
    function automatic logic sel_in(input logic [15:0] v, input logic [3:0] i);
        return v[i];
    endfunction : sel_in
endpackage : alarm_seq_pkg
